// [include/dram_ctl_regs.vh]
// Timing constants and encodings for the 4K x 1 dynamic RAM controller
`ifndef DRAM_CTL_REGS_VH
`define DRAM_CTL_REGS_VH

// ****************************************
// Clock
// ****************************************
`define CLK_PERIOD_NS      10

// ****************************************
// Strobe timing in ns (least times)
// ****************************************
`define T_CE_HIGH_NS       300
`define T_CE_LOW_NS        130
`define T_RMW_HIGH_NS      540
`define T_WRITE_SETUP_NS   240
`define T_ADDR_HOLD_NS     150
`define T_DATA_HOLD_NS     40
`define T_ACCESS_NS        280

// Cycle counts, least times rounded up
`define CYC(ns)            (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CE_HIGH_CYC        `CYC(`T_CE_HIGH_NS)
`define CE_LOW_CYC         `CYC(`T_CE_LOW_NS)
`define RMW_HIGH_CYC       `CYC(`T_RMW_HIGH_NS)
`define WRITE_SETUP_CYC    `CYC(`T_WRITE_SETUP_NS)
`define ADDR_HOLD_CYC      `CYC(`T_ADDR_HOLD_NS)
`define DATA_HOLD_CYC      `CYC(`T_DATA_HOLD_NS)
`define ACCESS_CYC         `CYC(`T_ACCESS_NS)

// ****************************************
// Refresh
// ****************************************
`define REFRESH_ROWS       64
`define T_REFRESH_STEP_NS  31250
`define REFRESH_STEP_CYC   (`T_REFRESH_STEP_NS / `CLK_PERIOD_NS)

// ****************************************
// Command encodings
// ****************************************
`define OP_READ            2'd0
`define OP_WRITE           2'd1
`define OP_RMW             2'd2

`endif

// [hdl/dram_ctl.v]
// Host-side controller that runs access and refresh cycles on a 4K x 1 dynamic RAM
`timescale 1ns/100ps
`include "dram_ctl_regs.vh"

module dram_ctl #(
  parameter AW               = 12,
  parameter REFRESH_STEP_CYC = `REFRESH_STEP_CYC
) (
  input  wire          sys_clk,
  input  wire          resetn,
  input  wire          req_valid,
  output wire          req_ready,
  input  wire [1:0]    req_op,
  input  wire [AW-1:0] req_addr,
  input  wire          req_wdata,
  output reg           rsp_valid,
  output reg           rsp_rdata,
  input  wire          permanent_select,
  output reg           chip_enable,
  output reg           select_n,
  output reg [AW-1:0]  bit_address,
  output reg           read_write,
  output reg           write_bit_in,
  input  wire          data_out_n
);

  // ****************************************
  // States
  // ****************************************
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_HIGH  = 5'h02;
  localparam [4:0] ST_HOLD  = 5'h04;
  localparam [4:0] ST_LOW   = 5'h08;
  localparam [4:0] ST_WAIT  = 5'h10;

  // Cycle counts worked out as integers, then cut to the counter width
  localparam integer HIGH_I = `CE_HIGH_CYC;
  localparam integer RMW_I  = `RMW_HIGH_CYC;
  localparam integer WSET_I = `WRITE_SETUP_CYC;
  localparam integer HOLD_I = `ADDR_HOLD_CYC;
  localparam integer LOW_I  = `CE_LOW_CYC;
  localparam integer ACC_I  = `ACCESS_CYC;

  localparam [9:0] HIGH_N   = HIGH_I[9:0];
  localparam [9:0] RMW_N    = RMW_I[9:0];
  localparam [9:0] WSET_N   = WSET_I[9:0];
  localparam [9:0] HOLD_N   = HOLD_I[9:0];
  localparam [9:0] LOW_N    = LOW_I[9:0];
  localparam [9:0] ACC_N    = ACC_I[9:0];

  reg [4:0]    state_q;
  reg [9:0]    cnt_q;
  reg [1:0]    op_q;
  reg          is_refresh_q;
  reg [5:0]    row_q;
  reg [6:0]    pend_q;
  reg [15:0]   tick_q;
  reg          dout_s1_q;
  reg          dout_s2_q;

  wire         refresh_due = (pend_q != 7'h00);
  wire         start       = (state_q == ST_IDLE) && (refresh_due || req_valid);
  wire [9:0]   high_len    = (op_q == `OP_RMW) ? RMW_N : HIGH_N;
  // Write point: write line falls so the write window ends with the strobe
  wire [9:0]   wr_point    = high_len - WSET_N;

  // User request taken only when no refresh is owed
  assign req_ready = (state_q == ST_IDLE) && !refresh_due;

  // ****************************************
  // Pin synchroniser for data-out
  // ****************************************
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dout_s1_q <= 1'b0;
      dout_s2_q <= 1'b0;
    end else begin
      dout_s1_q <= data_out_n;
      dout_s2_q <= dout_s1_q;
    end
  end

  // ****************************************
  // Refresh timer; owed rows counted so a long user burst cannot lose one
  // ****************************************
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tick_q <= 16'h0000;
      pend_q <= 7'h00;
    end else begin
      if (tick_q == REFRESH_STEP_CYC[15:0] - 16'h0001) begin
        tick_q <= 16'h0000;
      end else begin
        tick_q <= tick_q + 16'h0001;
      end
      // Neither wins: a new tick and a served row cancel out
      if ((tick_q == REFRESH_STEP_CYC[15:0] - 16'h0001) && !(start && refresh_due)) begin
        pend_q <= pend_q + 7'h01;
      end else if (!(tick_q == REFRESH_STEP_CYC[15:0] - 16'h0001) && start && refresh_due) begin
        pend_q <= pend_q - 7'h01;
      end
    end
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 10'h000;
      op_q         <= `OP_READ;
      is_refresh_q <= 1'b0;
      row_q        <= 6'h00;
      chip_enable  <= 1'b0;
      select_n     <= 1'b1;
      bit_address  <= {AW{1'b0}};
      read_write   <= 1'b1;
      write_bit_in <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          select_n <= !permanent_select;
          if (refresh_due) begin
            // Refresh is a read on the next row; high bits left as is
            bit_address[5:0] <= row_q;
            row_q            <= row_q + 6'h01;
            read_write       <= 1'b1;
            select_n         <= 1'b1;
            op_q             <= `OP_READ;
            is_refresh_q     <= 1'b1;
            chip_enable      <= 1'b1;
            cnt_q            <= 10'h000;
            state_q          <= ST_HIGH;
          end else if (req_valid) begin
            bit_address  <= req_addr;
            write_bit_in <= req_wdata;
            op_q         <= req_op;
            read_write   <= (req_op != `OP_WRITE);
            select_n     <= 1'b0;
            is_refresh_q <= 1'b0;
            chip_enable  <= 1'b1;
            cnt_q        <= 10'h000;
            state_q      <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // Full length always, refresh included; nothing cuts it short
          cnt_q <= cnt_q + 10'h001;
          if (op_q == `OP_RMW && cnt_q == wr_point) begin
            read_write <= 1'b0;
          end
          // Read half of a read-modify-write, past access time, before the write lands
          if (op_q == `OP_RMW && cnt_q == ACC_N + 10'h002) begin
            rsp_rdata <= !dout_s2_q;
          end
          if (cnt_q == high_len - 10'h001) begin
            chip_enable <= 1'b0;
            cnt_q       <= 10'h000;
            state_q     <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Address, select, data and write line held past strobe fall
          cnt_q <= cnt_q + 10'h001;
          // Plain read: synchroniser lag puts the sample here, data still from before the fall
          if (!is_refresh_q && op_q != `OP_WRITE && op_q != `OP_RMW && cnt_q == 10'h000) begin
            rsp_rdata <= !dout_s2_q;
          end
          if (cnt_q == HOLD_N - 10'h001) begin
            read_write <= 1'b1;
            select_n   <= !permanent_select;
            rsp_valid  <= !is_refresh_q;
            cnt_q      <= HOLD_N;
            state_q    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Remaining precharge time before the next strobe
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q >= LOW_N - 10'h001) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q     <= ST_IDLE;
          chip_enable <= 1'b0;
        end
      endcase
    end
  end

endmodule // dram_ctl

// [tb/dram_ctl_properties.sv]
// Pin sequencing assertions for the dynamic RAM controller
`timescale 1ns/100ps
module dram_ctl_properties #(
  parameter AW               = 12,
  parameter REFRESH_STEP_CYC = 200
) (
  input wire          sys_clk,
  input wire          resetn,
  input wire          rsp_valid,
  input wire          chip_enable,
  input wire          select_n,
  input wire [AW-1:0] bit_address,
  input wire          read_write,
  input wire          write_bit_in
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Cycles since a refresh strobe; a stalled refresh shows as growth
  reg [15:0] gap_q;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) gap_q <= 16'h0;
    else if (chip_enable && select_n) gap_q <= 16'h0;
    else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h1;
  end
  sequence strobe_up; $rose(chip_enable); endsequence
  sequence held_low; !chip_enable[*8] ##1 !chip_enable[*5]; endsequence
  chk_strobe_whole: assert property (strobe_up |-> ##29 chip_enable) else $error("strobe cut short");
  chk_low_gap: assert property ($fell(chip_enable) |-> held_low) else $error("strobe low too short");
  chk_select_kept: assert property (chip_enable && $past(chip_enable) |-> $stable(select_n)) else $error("select moved");
  chk_data_hold: assert property ($fell(chip_enable) |-> $stable(write_bit_in)[*4]) else $error("data moved");
  chk_refresh_read: assert property ((strobe_up and select_n) |-> read_write) else $error("refresh writes");
  chk_refresh_upper: assert property ((strobe_up and select_n) |-> $stable(bit_address[AW-1:6])) else $error("rows");
  chk_refresh_due: assert property (gap_q <= REFRESH_STEP_CYC + 100) else $error("refresh late");
  chk_rmw_window: assert property (chip_enable && $fell(read_write) |-> chip_enable[*8]) else $error("rmw");
  chk_answer_time: assert property ($fell(chip_enable) && !select_n |-> ##[13:17] rsp_valid) else $error("rsp");
endmodule // dram_ctl_properties
bind dram_ctl dram_ctl_properties #(.AW(AW), .REFRESH_STEP_CYC(REFRESH_STEP_CYC)) chk_u (.sys_clk(sys_clk),
  .resetn(resetn), .rsp_valid(rsp_valid), .chip_enable(chip_enable), .select_n(select_n),
  .bit_address(bit_address), .read_write(read_write), .write_bit_in(write_bit_in));

// [tb/dram_model.sv]
// Behavioural 4K x 1 dynamic RAM facing the controller
`timescale 1ns/100ps
module dram_model (
  input  wire        chip_enable,
  input  wire        select_n,
  input  wire [11:0] bit_address,
  input  wire        read_write,
  input  wire        write_bit_in,
  output reg         data_out_n
);
  reg [4095:0] cell_q;
  reg [11:0]   addr_q;
  reg          sel_n_q;
  initial data_out_n = 1'b0;
  // Rise latches select and address; floating output toggles so stale data never passes
  always @(posedge chip_enable) begin
    addr_q = bit_address;
    sel_n_q = select_n;
    if (!sel_n_q) begin
      data_out_n = 1'b0;
      #200 data_out_n = ~cell_q[addr_q];
    end else begin
      data_out_n = ~data_out_n;
    end
  end
  // Fall stores the unlatched data if write is low, then standby
  always @(negedge chip_enable) begin
    if (!sel_n_q && !read_write) cell_q[addr_q] = write_bit_in;
    data_out_n = ~data_out_n;
  end
endmodule // dram_model

// [tb/testbench.sv]
// Self-checking bench for the dynamic RAM controller
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  reg         sys_clk, resetn, req_valid, req_wdata, permanent_select;
  reg  [1:0]  req_op;
  reg  [11:0] req_addr;
  wire        req_ready, rsp_valid, rsp_rdata, chip_enable, select_n, read_write, write_bit_in, data_out_n;
  wire [11:0] bit_address;
  integer     err_total = 0, tests_run = 0, cyc = 0, n_ref = 0, i;
  reg  [63:0] rows = 64'h0;
  reg  [11:0] adr [0:3];
  dram_ctl #(.AW(12), .REFRESH_STEP_CYC(200)) dut_u (.sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .permanent_select(permanent_select), .chip_enable(chip_enable), .select_n(select_n),
    .bit_address(bit_address), .read_write(read_write), .write_bit_in(write_bit_in), .data_out_n(data_out_n));
  dram_model mem_u (.chip_enable(chip_enable), .select_n(select_n), .bit_address(bit_address),
    .read_write(read_write), .write_bit_in(write_bit_in), .data_out_n(data_out_n));
  initial begin sys_clk = 1'b0; forever #5 sys_clk = ~sys_clk; end
  // Refresh rows seen on the pins
  always @(posedge chip_enable) if (select_n) begin rows[bit_address[5:0]] = 1'b1; n_ref = n_ref + 1; end
  // Watchdog against a hung handshake
  always @(posedge sys_clk) begin cyc = cyc + 1; if (cyc == 40000) begin err_total++; print_verdict; end end
  task print_verdict; begin
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  // One request held until taken, then wait for its answer pulse
  task acc(input [1:0] op, input [11:0] a, input d); begin
    @(negedge sys_clk); req_valid = 1'b1; req_op = op; req_addr = a; req_wdata = d;
    while (req_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk); req_valid = 1'b0;
    while (rsp_valid !== 1'b1) @(negedge sys_clk);
  end endtask
  task test_wr_rd; begin
    for (i = 0; i < 4; i++) acc(2'd1, adr[i], i[0]);
    for (i = 0; i < 4; i++) begin acc(2'd0, adr[i], 1'b0); `CHK("rdata", i[0], rsp_rdata) end
    $display("test_wr_rd done");
  end endtask
  task test_rmw; begin
    acc(2'd2, 12'h5a5, 1'b0); `CHK("rmw old", 1'b1, rsp_rdata)
    acc(2'd3, 12'h5a5, 1'b1); `CHK("rmw new", 1'b0, rsp_rdata)
    acc(2'd0, 12'h5a5, 1'b0); `CHK("op3 no write", 1'b0, rsp_rdata)
    $display("test_rmw done");
  end endtask
  task test_perm; begin
    // Two idle edges in a row with no refresh owed, so no refresh deselect hides the level
    permanent_select = 1'b1; i = 0;
    while (i < 2) begin @(negedge sys_clk); i = (req_ready === 1'b1) ? i + 1 : 0; end
    `CHK("idle select", 1'b0, select_n)
    acc(2'd0, 12'hfff, 1'b0); `CHK("perm rdata", 1'b1, rsp_rdata)
    permanent_select = 1'b0; $display("test_perm done");
  end endtask
  task test_refresh; begin
    while (n_ref < 64) @(negedge sys_clk);
    `CHK("rows", 64'hffffffffffffffff, rows)
    acc(2'd0, 12'h000, 1'b0); `CHK("kept", 1'b0, rsp_rdata)
    $display("test_refresh done");
  end endtask
  initial begin
    resetn = 1'b0; req_valid = 1'b0; req_op = 2'd0; req_addr = 12'h0; req_wdata = 1'b0; permanent_select = 1'b0;
    adr[0] = 12'h000; adr[1] = 12'hfff; adr[2] = 12'h03f; adr[3] = 12'h5a5;
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    test_wr_rd; test_rmw; test_perm; test_refresh;
    print_verdict;
  end
endmodule // testbench
